// ---- include/ptt_defines.vh ----
// Purpose: constants for the periodic tick timer
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses
// Notes:   register fields are 8 bits wide, upper bus bits read zero
// Function
// RL1: Start bit begins and ends counting
// RL2: Read-only status shows counter actually running
// RL3: Forced stop halts at once, reads zero
// RL4: Edge flag writable, zero means none
// RL5: Underflow flag set by hardware, zero clears
// RL6: Mode field 000 selects interval timer
// RL7: Source field 001 selects clock over eight
// RL8: Source gate bit zero passes the source
// RL9: Software zeroes pin fields in timer mode
// RL10: Software keeps LIN select bit at zero
// RL11: Prescaler counts source, any value 0-255
// RL12: Main counter steps on prescaler underflow
// RL13: Software loads 7Ch and 63h for tick
// RL14: Priority field 000 disables the interrupt
// RL15: Request bit readable, zero write clears it
// RL16: Software stops and polls before reconfiguring
// RL17: Software clears request, starts, polls status
// RL18: Software waits for request, then clears it
// RL19: Application tick period is 5 ms
// RL20: Underflow reloads, sets flag and request
// RL21: Status follows start within few cycles
`ifndef PTT_DEFINES_VH
`define PTT_DEFINES_VH

// ==================================================
// Register byte offsets
`define PTT_OFS_INT_CTL   8'h00
`define PTT_OFS_CTL_STAT  8'h04
`define PTT_OFS_MODE_CFG  8'h08
`define PTT_OFS_PIN_CTL   8'h0c
`define PTT_OFS_PRESCALE  8'h10
`define PTT_OFS_MAIN_CNT  8'h14

// ==================================================
// Control/status bit positions
`define PTT_CS_GO         0
`define PTT_CS_RUNNING    1
`define PTT_CS_HALT       2
`define PTT_CS_EDGE       4
`define PTT_CS_UNDF       5

// ==================================================
// Mode register fields
`define PTT_MD_MODE_LSB   0
`define PTT_MD_SRC_LSB    4
`define PTT_MD_GATE_OFF   7
`define PTT_MODE_TIMER    3'h0
`define PTT_SRC_DIV1      3'h0
`define PTT_SRC_DIV8      3'h1
`define PTT_SRC_DIV2      3'h3

// ==================================================
// Interrupt control fields
`define PTT_IC_LVL_LSB    0
`define PTT_IC_REQ        3
`define PTT_LVL_OFF       3'h0

// ==================================================
// Reset values and timing
`define PTT_RST_BYTE      8'h00
`define PTT_RST_PRESCALE  8'hff
`define PTT_RST_MAIN      8'hff
`define PTT_SYNC_STAGES   2

`endif

// ---- tb/ptt_timer_properties.sv ----
// Purpose: port assertions for the tick timer
// Assumes: bound to every ptt_timer
// Notes:   read data is judged in its ack cycle
`timescale 1ns/100ps
`include "ptt_defines.vh"

module ptt_timer_properties (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Timer
    input wire        tick_o,
    input wire        int_req_o,
    input wire [2:0]  int_level_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire rd = wb_ack_o && !wb_we_i;

    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_dat_hi;
        rd |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("high bits set");
    property p_halt_zero;
        rd && wb_adr_i == `PTT_OFS_CTL_STAT |-> wb_dat_o[2] == 1'b0 && wb_dat_o[4] == 1'b0;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("halt bit read");
    property p_unmapped;
        rd && wb_adr_i > `PTT_OFS_MAIN_CNT |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole reads data");
    property p_lvl_off;
        int_level_o == 3'h0 |-> !int_req_o;
    endproperty
    a_lvl_off: assert property (p_lvl_off) else $error("masked request");
    property p_lvl_read;
        rd && wb_adr_i == `PTT_OFS_INT_CTL |-> wb_dat_o[2:0] == int_level_o;
    endproperty
    a_lvl_read: assert property (p_lvl_read) else $error("level mismatch");
    property p_tick_req;
        tick_o && int_level_o != 3'h0 |-> ##[0:2] int_req_o;
    endproperty
    a_tick_req: assert property (p_tick_req) else $error("no request");
endmodule

bind ptt_timer ptt_timer_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tick_o(tick_o), .int_req_o(int_req_o),
    .int_level_o(int_level_o));

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the tick timer
// Assumes: default divider width
// Notes:   tick gaps come from a cycle model
`timescale 1ns/100ps
`include "ptt_defines.vh"

module testbench;
    // Entry: divisor, mode, prescaler, main
    localparam [127:0] CFG = {32'h01000203, 32'h08100000, 32'h0230ff00, 32'h20200102};
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         req = 1'b0;
    reg         we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [3:0]  sel = 4'hf;
    reg  [31:0] wdat = 32'h0;
    reg  [31:0] q;
    reg  [31:0] e;
    wire [31:0] rdat;
    wire        ack;
    wire        tick;
    wire        irq;
    wire [2:0]  lvl;
    integer     fails = 0;
    integer     checks = 0;
    integer     seed = 32'hfe10;
    integer     i;
    integer     g;

    ptt_timer u_ptt_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tick_o(tick), .int_req_o(irq), .int_level_o(lvl));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task chk(input [31:0] s, input [31:0] x);
        begin
            checks = checks + 1;
            if (s !== x)
            begin
                fails = fails + 1;
                $display("[FAIL] %0t seen %h exp %h", $time, s, x);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // A wait that runs out ends the run at once
    task bound(input integer n, input integer lim);
        begin
            chk(n >= lim, 1'b0);
            if (n >= lim)
                final_report;
        end
    endtask

    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            req <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk_i);
            for (n = 0; ack !== 1'b1 && n < 50; n = n + 1)
                @(posedge clk_i);
            q = rdat;
            req <= 1'b0;
            bound(n, 50);
        end
    endtask

    task rc(input [7:0] a, input [31:0] x);
        begin
            wb(1'b0, a, 32'h0);
            chk(q, x);
        end
    endtask

    task poll(input b);
        integer n;
        begin
            wb(1'b0, `PTT_OFS_CTL_STAT, 32'h0);
            for (n = 0; q[1] !== b && n < 20; n = n + 1)
                wb(1'b0, `PTT_OFS_CTL_STAT, 32'h0);
            bound(n, 20);
        end
    endtask

    // Cycles between two ticks
    task gap;
        begin
            for (g = 0; tick !== 1'b1 && g < 13000; g = g + 1)
                @(posedge clk_i);
            @(posedge clk_i);
            for (g = 1; tick !== 1'b1 && g < 13000; g = g + 1)
                @(posedge clk_i);
            bound(g, 13000);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rc({i[5:0], 2'b00}, (i > 3) ? 32'hff : 32'h0);
        for (i = 0; i < 6; i = i + 1)
        begin
            // Bit 3 stays clear: reserved in mode, LIN select in pin control
            e = $random(seed) & 32'hf7;
            wb(1'b1, i[0] ? `PTT_OFS_MODE_CFG : `PTT_OFS_PIN_CTL, e);
            rc(i[0] ? `PTT_OFS_MODE_CFG : `PTT_OFS_PIN_CTL, e);
        end
        sel <= 4'he;
        wb(1'b1, `PTT_OFS_MODE_CFG, 32'h0);
        sel <= 4'hf;
        rc(`PTT_OFS_MODE_CFG, e);
        wb(1'b1, 8'h18, 32'hff);
        rc(8'h18, 32'h0);
        wb(1'b1, `PTT_OFS_PIN_CTL, 32'h0);
        wb(1'b1, `PTT_OFS_INT_CTL, 32'h5);
        rc(`PTT_OFS_INT_CTL, 32'h5);
        chk(lvl, 3'h5);
        for (i = 0; i < 4; i = i + 1)
        begin
            e = CFG[32*i +: 32];
            wb(1'b1, `PTT_OFS_MODE_CFG, e[23:16]);
            wb(1'b1, `PTT_OFS_PRESCALE, e[15:8]);
            wb(1'b1, `PTT_OFS_MAIN_CNT, e[7:0]);
            wb(1'b1, `PTT_OFS_CTL_STAT, 32'h1);
            poll(1'b1);
            gap;
            chk(g, e[31:24] * (e[15:8] + 1) * (e[7:0] + 1));
            rc(`PTT_OFS_INT_CTL, 32'hd);
            chk(irq, 1'b1);
            rc(`PTT_OFS_CTL_STAT, 32'h23);
            wb(1'b1, `PTT_OFS_CTL_STAT, 32'h0);
            poll(1'b0);
            // A late underflow may land during the stop
            wb(1'b1, `PTT_OFS_CTL_STAT, 32'h0);
            rc(`PTT_OFS_CTL_STAT, 32'h0);
            wb(1'b1, `PTT_OFS_INT_CTL, 32'h5);
            rc(`PTT_OFS_INT_CTL, 32'h5);
            chk(irq, 1'b0);
        end
        wb(1'b1, `PTT_OFS_INT_CTL, 32'h0);
        wb(1'b1, `PTT_OFS_CTL_STAT, 32'h1);
        poll(1'b1);
        gap;
        rc(`PTT_OFS_INT_CTL, 32'h8);
        chk(irq, 1'b0);
        wb(1'b1, `PTT_OFS_CTL_STAT, 32'h5);
        wb(1'b0, `PTT_OFS_CTL_STAT, 32'h0);
        chk(q & 32'h7, 32'h0);
        for (i = 0; i < 2; i = i + 1)
        begin
            wb(1'b1, `PTT_OFS_MODE_CFG, i ? 32'h1 : 32'h80);
            wb(1'b1, `PTT_OFS_MAIN_CNT, 32'h9);
            wb(1'b1, `PTT_OFS_CTL_STAT, 32'h1);
            poll(1'b1);
            repeat (100) @(posedge clk_i);
            rc(`PTT_OFS_MAIN_CNT, 32'h9);
            wb(1'b1, `PTT_OFS_CTL_STAT, 32'h0);
            poll(1'b0);
        end
        wb(1'b1, `PTT_OFS_PRESCALE, 32'h7c);
        wb(1'b1, `PTT_OFS_MAIN_CNT, 32'h63);
        rc(`PTT_OFS_PRESCALE, 32'h7c);
        rc(`PTT_OFS_MAIN_CNT, 32'h63);
        // Full tick with the application divisors on the undivided clock
        wb(1'b1, `PTT_OFS_INT_CTL, 32'h0);
        wb(1'b1, `PTT_OFS_MODE_CFG, 32'h0);
        wb(1'b1, `PTT_OFS_CTL_STAT, 32'h1);
        poll(1'b1);
        gap;
        chk(g, 125 * 100);
        rc(`PTT_OFS_INT_CTL, 32'h8);
        wb(1'b1, `PTT_OFS_INT_CTL, 32'h0);
        rc(`PTT_OFS_INT_CTL, 32'h0);
        // Reset in mid-run returns outputs and registers to rest
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({tick, irq, lvl}, 5'h00);
        rc(`PTT_OFS_CTL_STAT, 32'h0);
        rc(`PTT_OFS_PRESCALE, 32'hff);
        final_report;
    end
endmodule

// ---- verilog/ptt_timer.v ----
// Purpose: 8-bit prescaler and 8-bit down counter, interval timer mode
// Assumes: one clock, synchronous active-high reset, classic Wishbone
// Notes:   only the interval timer mode counts; other modes hold still
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ptt_defines.vh"

module ptt_timer #(
    parameter DIV_W = 5
)
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Timer status
    output reg         tick_o,
    output reg         int_req_o,
    output reg  [2:0]  int_level_o
);

// ==================================================
// Bus decode
wire        acc_go;
wire        wr_go;
wire        lane0;
wire [7:0]  wbyte;
wire        hit_ic;
wire        hit_cs;
wire        hit_md;
wire        hit_pc;
wire        hit_ps;
wire        hit_mc;

assign acc_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign lane0  = wb_sel_i[0];
assign wr_go  = acc_go & wb_we_i & lane0;
assign wbyte  = wb_dat_i[7:0];
assign hit_ic = (wb_adr_i == `PTT_OFS_INT_CTL);
assign hit_cs = (wb_adr_i == `PTT_OFS_CTL_STAT);
assign hit_md = (wb_adr_i == `PTT_OFS_MODE_CFG);
assign hit_pc = (wb_adr_i == `PTT_OFS_PIN_CTL);
assign hit_ps = (wb_adr_i == `PTT_OFS_PRESCALE);
assign hit_mc = (wb_adr_i == `PTT_OFS_MAIN_CNT);

wire wr_ic;
wire wr_cs;
wire wr_md;
wire wr_pc;
wire wr_ps;
wire wr_mc;

assign wr_ic = wr_go & hit_ic;
assign wr_cs = wr_go & hit_cs;
assign wr_md = wr_go & hit_md;
assign wr_pc = wr_go & hit_pc;
assign wr_ps = wr_go & hit_ps;
assign wr_mc = wr_go & hit_mc;

// ==================================================
// Register state
reg         count_go_r;
reg         edge_seen_flag_r;
reg         underflow_flag_r;
reg  [2:0]  op_mode_r;
reg  [2:0]  source_sel_r;
reg         source_gate_off_r;
reg  [7:0]  pin_ctl_r;
reg  [2:0]  priority_r;
reg         request_pending_r;
reg  [7:0]  pre_reload_r;
reg  [7:0]  main_reload_r;
reg  [7:0]  pre_cnt_r;
reg  [7:0]  main_cnt_r;
reg  [`PTT_SYNC_STAGES-1:0] go_sync_r;
reg         counting_flag_r;
reg  [DIV_W-1:0] div_r;

wire halt_wr;
assign halt_wr = wr_cs & wbyte[`PTT_CS_HALT];

// ==================================================
// Count source selection
reg src_tick;

always @*
begin
    case (source_sel_r)
        `PTT_SRC_DIV1: src_tick = 1'b1;
        `PTT_SRC_DIV8: src_tick = (div_r[2:0] == 3'h7);  // see RL7
        `PTT_SRC_DIV2: src_tick = div_r[0];
        default:       src_tick = (div_r == {DIV_W{1'b1}});
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        div_r <= {DIV_W{1'b0}};
    end
    else
    begin
        div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
end

// Counting needs the start, the synchronised status, timer mode and an open gate
wire count_en;
assign count_en = counting_flag_r & count_go_r                  // see RL1
                & (op_mode_r == `PTT_MODE_TIMER)                 // see RL6
                & ~source_gate_off_r                             // see RL8
                & src_tick;

wire pre_zero;
wire main_zero;
wire pre_undf;
wire main_undf;

assign pre_zero  = (pre_cnt_r == 8'h00);
assign main_zero = (main_cnt_r == 8'h00);
assign pre_undf  = count_en & pre_zero;
assign main_undf = pre_undf & main_zero;

// ==================================================
// Start bit, forced stop and status flag
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        count_go_r      <= 1'b0;
        go_sync_r       <= {`PTT_SYNC_STAGES{1'b0}};
        counting_flag_r <= 1'b0;
    end
    else if (halt_wr)
    begin
        // Forced stop wins over a start written in the same byte
        count_go_r      <= 1'b0;                                 // see RL3
        go_sync_r       <= {`PTT_SYNC_STAGES{1'b0}};
        counting_flag_r <= 1'b0;
    end
    else
    begin
        if (wr_cs)
        begin
            count_go_r <= wbyte[`PTT_CS_GO];                     // see RL1
        end
        // Short fixed delay keeps software polling loops bounded
        go_sync_r       <= {go_sync_r[`PTT_SYNC_STAGES-2:0], count_go_r};
        counting_flag_r <= go_sync_r[`PTT_SYNC_STAGES-1]        // see RL21
                         & count_go_r;                           // see RL2
    end
end

// ==================================================
// Prescaler and main counter
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        pre_reload_r  <= `PTT_RST_PRESCALE;
        main_reload_r <= `PTT_RST_MAIN;
        pre_cnt_r     <= `PTT_RST_PRESCALE;
        main_cnt_r    <= `PTT_RST_MAIN;
    end
    else
    begin
        if (wr_ps)
        begin
            pre_reload_r <= wbyte;                               // see RL11
        end
        if (wr_mc)
        begin
            main_reload_r <= wbyte;                              // see RL12
        end

        if (halt_wr)
        begin
            pre_cnt_r  <= pre_reload_r;
            main_cnt_r <= main_reload_r;
        end
        else if (wr_ps & ~counting_flag_r)
        begin
            // While stopped a write lands in the counter directly
            pre_cnt_r <= wbyte;
        end
        else if (main_undf)
        begin
            pre_cnt_r <= pre_reload_r;                           // see RL20
        end
        else if (pre_undf)
        begin
            pre_cnt_r <= pre_reload_r;
        end
        else if (count_en)
        begin
            pre_cnt_r <= pre_cnt_r - 8'h01;                      // see RL11
        end

        if (!halt_wr)
        begin
            if (wr_mc & ~counting_flag_r)
            begin
                main_cnt_r <= wbyte;
            end
            else if (main_undf)
            begin
                main_cnt_r <= main_reload_r;                     // see RL20
            end
            else if (pre_undf)
            begin
                main_cnt_r <= main_cnt_r - 8'h01;                // see RL12
            end
        end
    end
end

// ==================================================
// Flags: a hardware set wins over a software clear
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        underflow_flag_r  <= 1'b0;
        edge_seen_flag_r  <= 1'b0;
        request_pending_r <= 1'b0;
    end
    else
    begin
        if (main_undf)
        begin
            underflow_flag_r <= 1'b1;                            // see RL20
        end
        else if (wr_cs & ~wbyte[`PTT_CS_UNDF])
        begin
            underflow_flag_r <= 1'b0;                            // see RL5
        end

        // No edge source exists in timer mode, so the flag only clears
        if (wr_cs & ~wbyte[`PTT_CS_EDGE])
        begin
            edge_seen_flag_r <= 1'b0;                            // see RL4
        end

        if (main_undf)
        begin
            request_pending_r <= 1'b1;                           // see RL20
        end
        else if (wr_ic & ~wbyte[`PTT_IC_REQ])
        begin
            request_pending_r <= 1'b0;                           // see RL15
        end
    end
end

// ==================================================
// Plain configuration registers
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        op_mode_r         <= `PTT_MODE_TIMER;
        source_sel_r      <= `PTT_SRC_DIV1;
        source_gate_off_r <= 1'b0;
        pin_ctl_r         <= `PTT_RST_BYTE;
        priority_r        <= `PTT_LVL_OFF;
    end
    else
    begin
        if (wr_md)
        begin
            op_mode_r         <= wbyte[`PTT_MD_MODE_LSB +: 3];   // see RL6
            source_sel_r      <= wbyte[`PTT_MD_SRC_LSB +: 3];    // see RL7
            source_gate_off_r <= wbyte[`PTT_MD_GATE_OFF];        // see RL8
        end
        if (wr_pc)
        begin
            pin_ctl_r <= wbyte;
        end
        if (wr_ic)
        begin
            priority_r <= wbyte[`PTT_IC_LVL_LSB +: 3];           // see RL14
        end
    end
end

// ==================================================
// Read mux
reg [7:0] rd_byte;

always @*
begin
    rd_byte = 8'h00;
    if (hit_ic)
    begin
        rd_byte = {4'h0, request_pending_r, priority_r};
    end
    else if (hit_cs)
    begin
        // Forced-stop bit always reads zero
        rd_byte = {2'b00, underflow_flag_r, edge_seen_flag_r,
                   2'b00, counting_flag_r, count_go_r};
    end
    else if (hit_md)
    begin
        rd_byte = {source_gate_off_r, source_sel_r, 1'b0, op_mode_r};
    end
    else if (hit_pc)
    begin
        rd_byte = pin_ctl_r;
    end
    else if (hit_ps)
    begin
        rd_byte = pre_cnt_r;
    end
    else if (hit_mc)
    begin
        rd_byte = main_cnt_r;
    end
end

// ==================================================
// Bus answer and status outputs
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o    <= 1'b0;
        wb_dat_o    <= 32'h0000_0000;
        tick_o      <= 1'b0;
        int_req_o   <= 1'b0;
        int_level_o <= `PTT_LVL_OFF;
    end
    else
    begin
        // Every address answers; unmapped reads give zero
        wb_ack_o <= acc_go;
        if (acc_go & ~wb_we_i)
        begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
        tick_o      <= main_undf;
        // Level zero keeps the request off the line
        int_req_o   <= request_pending_r
                     & (priority_r != `PTT_LVL_OFF);             // see RL14
        int_level_o <= priority_r;
    end
end

endmodule
